// ---- hw/pms_pkg.sv ----
// constants, register map and mode encoding for the power mode sequencer
package pms_pkg;
  localparam int PMS_PORT_N = 8;
  localparam int PMS_IRQ_N = 8;
  localparam int PMS_AW = 8;

  localparam logic [7:0] PMS_OFS_CLK_MODE = 8'h00;
  localparam logic [7:0] PMS_OFS_PWR_CTRL = 8'h04;
  localparam logic [7:0] PMS_OFS_SUBCLK = 8'h08;
  localparam logic [7:0] PMS_OFS_WAKE_EN = 8'h0C;
  localparam logic [7:0] PMS_OFS_STATUS = 8'h10;

  localparam int PMS_CM_DIV_LO = 5;
  localparam int PMS_CM_SLOW_RDY = 3;
  localparam int PMS_CM_FAST_RDY = 2;
  localparam int PMS_CM_IDLE = 1;
  localparam int PMS_CM_FAST_SEL = 0;
  localparam int PMS_PC_KEEP = 7;
  localparam int PMS_PC_SUBF = 3;
  localparam int PMS_ST_HALTED = 0;
  localparam int PMS_ST_EXPIRY = 1;
  localparam int PMS_ST_SLOW = 2;
  localparam int PMS_ST_MODE_LO = 4;

  localparam logic [2:0] PMS_DIV_RST = 3'h0;
  localparam logic PMS_IDLE_RST = 1'b1;
  localparam logic PMS_FAST_SEL_RST = 1'b1;
  localparam logic PMS_KEEP_RST = 1'b0;
  localparam logic [2:0] PMS_PC_LOW_RST = 3'h0;
  localparam logic [7:0] PMS_WAKE_EN_RST = 8'h00;
  // arbitrary values standing for the two defined sub clock codes
  localparam logic [6:0] PMS_SUBC_CODE_A = 7'h55;
  localparam logic [6:0] PMS_SUBC_CODE_B = 7'h2A;
  localparam logic [6:0] PMS_SUBC_RST = PMS_SUBC_CODE_A;

  localparam logic [1:0] PMS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PMS_RUN,
    PMS_FULL_STOP,
    PMS_STOP_SLOW,
    PMS_IDLE_OFF,
    PMS_IDLE_ON
  } pms_mode_e;
endpackage

// ---- hw/pms_power_mode_sequencer.sv ----
// power mode sequencer: run modes, halt modes, wake-up and control registers
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns

// Operation
// R1: idle without sysclk: cpu, sysclk stop; timebase, slow run
// R2: idle with sysclk: cpu stops, all clocks run
// R3: undefined subclock code sets fault; software-zero clears
// R4: power control bits 6..4 read zero
// R5: fast select 0, divider 000/001 gives slow mode
// R6: fast select 1 or divider 010..111 returns fast
// R7: software polls fast stable before trusting fast clock
// R8: on slow sysclk the fast oscillator stops
// R9: slow switch completes once slow oscillator stable
// R10: full stop: sysclk, watchdog, timebase off, watchdog cleared
// R11: stop keeping slow clock for enabled watchdog/undervolt
// R12: low-power entry keeps memory, registers, ports unchanged
// R13: halt sets halted flag, clears watchdog expiry flag
// R14: halt clears watchdog; counts on only if enabled
// R15: wake on port A fall, interrupt, watchdog overflow
// R16: sleeping watchdog overflow sets expiry, resets pc/sp
// R17: halted cleared by reset or clear-watchdog; set by halt
// R18: port A wake only where enabled; resume after halt
// R19: disabled irq or full stack: resume, irq stays pending
// R20: enabled irq with free stack: normal interrupt response
// R21: irq already pending at halt cannot wake
// R22: divider codes: slow, slow, fast/64 down to fast/2
// R23: fast stable low after reset, full stop, idle-off
// R24: mode chosen from settings sampled at halt
module pms_power_mode_sequencer
  import pms_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PMS_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PMS_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic wdt_enable,
  input wire logic undervolt_enable,
  input wire logic wdt_overflow,
  input wire logic fast_osc_ready,
  input wire logic slow_osc_ready,
  input wire logic [PMS_PORT_N-1:0] port_a_in,
  input wire logic [PMS_IRQ_N-1:0] irq_req,
  input wire logic [PMS_IRQ_N-1:0] irq_enable,
  input wire logic stack_full,
  output logic cpu_run,
  output logic state_hold,
  output logic sysclk_en,
  output logic sysclk_slow,
  output logic [2:0] sysclk_div_exp,
  output logic fast_osc_en,
  output logic slow_clk_en,
  output logic timebase_clk_en,
  output logic wdt_clk_en,
  output logic wdt_run,
  output logic wdt_clear,
  output logic wake_resume,
  output logic [PMS_IRQ_N-1:0] irq_service,
  output logic pc_sp_reset
);

  // slow clock picked by divider codes 000 and 001
  function automatic logic is_slow_sel(input logic fsel, input logic [2:0] div);
    is_slow_sel = !fsel && (div[2:1] == 2'b00);
  endfunction

  // power of two divide: 0 means undivided fast clock
  function automatic logic [2:0] div_exp(input logic fsel, input logic [2:0] div);
    if (fsel || div[2:1] == 2'b00) begin
      div_exp = 3'h0;
    end else begin
      div_exp = 3'h0 - div;
    end
  endfunction
  logic aw_held_reg;
  logic w_held_reg;
  logic [PMS_AW-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic wr_mapped;
  logic wr_cm;
  logic wr_pc;
  logic wr_sc;
  logic wr_we;
  logic [2:0] div_sel_reg;
  logic idle_on_halt_reg;
  logic fast_sel_reg;
  logic keep_sysclk_reg;
  logic subf_reg;
  logic [2:0] pc_low_reg;
  logic [6:0] subc_code_reg;
  logic [PMS_PORT_N-1:0] wake_en_reg;
  pms_mode_e mode_reg;
  pms_mode_e halt_target;
  logic run_slow_reg;
  logic wdt_keep_reg;
  logic halted_reg;
  logic expiry_reg;
  logic [PMS_PORT_N-1:0] pa_prev_reg;
  logic [PMS_IRQ_N-1:0] irq_blocked_reg;
  logic [2:0] div_out_reg;
  logic wdt_clear_reg;
  logic resume_reg;
  logic [PMS_IRQ_N-1:0] irq_service_reg;
  logic pc_sp_reset_reg;
  logic halt_ok;
  logic target_slow;
  logic fast_stable;
  logic subc_valid;
  logic [PMS_PORT_N-1:0] pa_fall;
  logic [PMS_IRQ_N-1:0] irq_wake;
  logic [PMS_IRQ_N-1:0] irq_serve;
  logic wake;
  // write path: address and data taken in either order, one at a time
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_mapped = (aw_addr_reg == PMS_OFS_CLK_MODE) || (aw_addr_reg == PMS_OFS_PWR_CTRL)
    || (aw_addr_reg == PMS_OFS_SUBCLK) || (aw_addr_reg == PMS_OFS_WAKE_EN)
    || (aw_addr_reg == PMS_OFS_STATUS);
  assign wr_cm = wr_fire && w_lane_reg && (aw_addr_reg == PMS_OFS_CLK_MODE);
  assign wr_pc = wr_fire && w_lane_reg && (aw_addr_reg == PMS_OFS_PWR_CTRL);
  assign wr_sc = wr_fire && w_lane_reg && (aw_addr_reg == PMS_OFS_SUBCLK);
  assign wr_we = wr_fire && w_lane_reg && (aw_addr_reg == PMS_OFS_WAKE_EN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[PMS_AW-1:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_byte_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= PMS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? PMS_RESP_OKAY : PMS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  // read path: one word answered the cycle after the address is taken
  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= PMS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= PMS_RESP_OKAY;
      unique case ({s_axi_araddr[PMS_AW-1:2], 2'b00})
        PMS_OFS_CLK_MODE: rdata_reg <= {24'h0, div_sel_reg, 1'b0, slow_osc_ready,
                                        fast_stable, idle_on_halt_reg, fast_sel_reg};
        PMS_OFS_PWR_CTRL: rdata_reg <= {24'h0, keep_sysclk_reg, 3'h0, // see R4
                                        subf_reg, pc_low_reg};
        PMS_OFS_SUBCLK: rdata_reg <= {25'h0, subc_code_reg};
        PMS_OFS_WAKE_EN: rdata_reg <= {24'h0, wake_en_reg};
        PMS_OFS_STATUS: rdata_reg <= {25'h0, mode_reg, 1'b0, run_slow_reg,
                                      expiry_reg, halted_reg};
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= PMS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // clock mode register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_sel_reg <= PMS_DIV_RST;
      idle_on_halt_reg <= PMS_IDLE_RST;
      fast_sel_reg <= PMS_FAST_SEL_RST;
    end else if (wr_cm) begin
      div_sel_reg <= w_byte_reg[7:PMS_CM_DIV_LO];
      idle_on_halt_reg <= w_byte_reg[PMS_CM_IDLE];
      fast_sel_reg <= w_byte_reg[PMS_CM_FAST_SEL];
    end
  end

  // power control: keep-sysclk bit and the plain flag bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keep_sysclk_reg <= PMS_KEEP_RST;
      pc_low_reg <= PMS_PC_LOW_RST;
    end else if (wr_pc) begin
      keep_sysclk_reg <= w_byte_reg[PMS_PC_KEEP];
      pc_low_reg <= w_byte_reg[2:0];
    end
  end
  assign subc_valid = (subc_code_reg == PMS_SUBC_CODE_A) || (subc_code_reg == PMS_SUBC_CODE_B);
  // hardware set beats a same-cycle software clear; writing 1 does nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      subf_reg <= 1'b0;
    end else if (!subc_valid) begin
      subf_reg <= 1'b1; // see R3
    end else if (wr_pc && !w_byte_reg[PMS_PC_SUBF]) begin
      subf_reg <= 1'b0; // see R3
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      subc_code_reg <= PMS_SUBC_RST;
      wake_en_reg <= PMS_WAKE_EN_RST;
    end else begin
      if (wr_sc) begin
        subc_code_reg <= w_byte_reg[6:0];
      end
      if (wr_we) begin
        wake_en_reg <= w_byte_reg;
      end
    end
  end

  // halt mode choice from the settings live at the halt
  assign halt_ok = halt_exec && (mode_reg == PMS_RUN);
  always_comb begin
    if (idle_on_halt_reg) begin
      halt_target = keep_sysclk_reg ? PMS_IDLE_ON : PMS_IDLE_OFF; // see R1, R2, R24
    end else if (wdt_enable || undervolt_enable) begin
      halt_target = PMS_STOP_SLOW; // see R11, R24
    end else begin
      halt_target = PMS_FULL_STOP; // see R10, R24
    end
  end

  // wake sources; irqs pending at halt are blocked until the next halt
  assign pa_fall = pa_prev_reg & ~port_a_in & wake_en_reg; // see R18
  assign irq_wake = irq_req & ~irq_blocked_reg; // see R21
  assign irq_serve = irq_wake & irq_enable;
  assign wake = (mode_reg != PMS_RUN) && ((|pa_fall) || (|irq_wake) || wdt_overflow); // see R15
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_prev_reg <= '0;
      irq_blocked_reg <= '0;
    end else begin
      pa_prev_reg <= port_a_in;
      if (halt_ok) begin
        irq_blocked_reg <= irq_req; // see R21
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= PMS_RUN;
      wdt_keep_reg <= 1'b0;
    end else if (halt_ok) begin
      mode_reg <= halt_target;
      wdt_keep_reg <= wdt_enable; // see R14, R24
    end else if (wake) begin
      mode_reg <= PMS_RUN; // see R15
    end
  end

  // run clock: switch only once the new source is stable
  assign target_slow = is_slow_sel(fast_sel_reg, div_sel_reg);
  // fast oscillator off while running slow and in the off modes
  assign fast_osc_en = ((mode_reg == PMS_RUN) || (mode_reg == PMS_IDLE_ON))
    && !(run_slow_reg && target_slow); // see R8, R23
  assign fast_stable = fast_osc_en && fast_osc_ready; // see R23
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_slow_reg <= 1'b0;
    end else if (mode_reg == PMS_RUN) begin
      if (target_slow && slow_osc_ready) begin
        run_slow_reg <= 1'b1; // see R5, R9
      end else if (!target_slow && fast_stable) begin
        run_slow_reg <= 1'b0; // see R6
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_out_reg <= 3'h0;
    end else begin
      div_out_reg <= run_slow_reg ? 3'h0 : div_exp(fast_sel_reg, div_sel_reg); // see R22
    end
  end

  // status flags; an overflow beats the clear done by a halt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halted_reg <= 1'b0; // see R17
    end else if (halt_ok) begin
      halted_reg <= 1'b1; // see R13, R17
    end else if (clr_wdt_exec) begin
      halted_reg <= 1'b0; // see R17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expiry_reg <= 1'b0;
    end else if (wdt_overflow) begin
      expiry_reg <= 1'b1; // see R16
    end else if (halt_ok) begin
      expiry_reg <= 1'b0; // see R13
    end
  end
  // one-cycle halt and wake answers to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_clear_reg <= 1'b0;
      resume_reg <= 1'b0;
      irq_service_reg <= '0;
      pc_sp_reset_reg <= 1'b0;
    end else begin
      wdt_clear_reg <= halt_ok; // see R10, R14
      resume_reg <= 1'b0;
      irq_service_reg <= '0;
      pc_sp_reset_reg <= 1'b0;
      if (wake) begin
        if (wdt_overflow) begin
          pc_sp_reset_reg <= 1'b1; // see R16
        end else if ((|irq_wake) && (|irq_serve) && !stack_full) begin
          irq_service_reg <= irq_serve; // see R20
        end else begin
          // irq flag left untouched so it is serviced later
          resume_reg <= 1'b1; // see R18, R19
        end
      end
    end
  end

  assign cpu_run = (mode_reg == PMS_RUN);
  // core freezes memory, registers and ports while this is high
  assign state_hold = (mode_reg != PMS_RUN); // see R12
  assign sysclk_en = (mode_reg == PMS_RUN) || (mode_reg == PMS_IDLE_ON); // see R1, R2
  assign sysclk_slow = run_slow_reg;
  assign sysclk_div_exp = div_out_reg;
  assign slow_clk_en = (mode_reg != PMS_FULL_STOP); // see R10, R11
  assign timebase_clk_en = (mode_reg == PMS_RUN) || (mode_reg == PMS_IDLE_OFF)
    || (mode_reg == PMS_IDLE_ON); // see R1, R2, R11
  assign wdt_run = (mode_reg == PMS_RUN) ? wdt_enable
    : ((mode_reg != PMS_FULL_STOP) && wdt_keep_reg); // see R10, R14
  assign wdt_clk_en = wdt_run;
  assign wdt_clear = wdt_clear_reg;
  assign wake_resume = resume_reg;
  assign irq_service = irq_service_reg;
  assign pc_sp_reset = pc_sp_reset_reg;
endmodule

// ---- bench/pms_core_model.sv ----
// core and oscillator stand-in facing the sequencer
`timescale 1ns/1ns
module pms_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic halt_req,
  input wire logic cpu_run,
  input wire logic fast_osc_en,
  input wire logic [3:0] osc_lag,
  output logic halt_exec,
  output logic fast_osc_ready,
  output logic slow_osc_ready
);
  logic [3:0] cnt_reg;
  // a stopped core cannot issue a halt
  always_ff @(posedge aclk) begin
    halt_exec <= aresetn && halt_req && cpu_run;
  end
  // lag 0 answers promptly, larger lags model a slow crystal
  always_ff @(posedge aclk) begin
    if (!aresetn || !fast_osc_en) begin
      cnt_reg <= 4'h0;
      fast_osc_ready <= 1'b0;
    end else if (cnt_reg < osc_lag) begin
      cnt_reg <= cnt_reg + 4'h1;
    end else begin
      fast_osc_ready <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    slow_osc_ready <= aresetn;
  end
endmodule

// ---- bench/pms_power_mode_sequencer_props.sv ----
// port assertions for the power mode sequencer
`timescale 1ns/1ns
module pms_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic halt_exec,
  input wire logic wdt_enable,
  input wire logic wdt_overflow,
  input wire logic slow_osc_ready,
  input wire logic cpu_run,
  input wire logic state_hold,
  input wire logic sysclk_en,
  input wire logic sysclk_slow,
  input wire logic [2:0] sysclk_div_exp,
  input wire logic fast_osc_en,
  input wire logic slow_clk_en,
  input wire logic timebase_clk_en,
  input wire logic wdt_run,
  input wire logic wdt_clear,
  input wire logic wake_resume,
  input wire logic pc_sp_reset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_halt;
    cpu_run && halt_exec;
  endsequence
  sequence s_sleep_ovf;
    !cpu_run && wdt_overflow;
  endsequence
  a_halt_stops_cpu: assert property (s_halt |=> !cpu_run && wdt_clear ##1 !wdt_clear)
    else $error("halt not taken");
  a_hold_level: assert property (state_hold == !cpu_run)
    else $error("hold level wrong");
  a_idle_keeps_clocks: assert property (!cpu_run && sysclk_en |->
    timebase_clk_en && slow_clk_en)
    else $error("idle clocks off");
  a_sleep_sys_off: assert property (!cpu_run && !timebase_clk_en |-> !sysclk_en)
    else $error("sysclk on in stop");
  a_slow_after_osc: assert property ($rose(sysclk_slow) |-> $past(slow_osc_ready))
    else $error("slow before osc ready");
  a_fast_osc_stop: assert property ($rose(sysclk_slow) |-> ##[0:2] !fast_osc_en)
    else $error("fast osc kept");
  a_slow_no_div: assert property (sysclk_slow |-> sysclk_div_exp == 3'h0)
    else $error("divider on slow");
  a_ovf_wakes: assert property (s_sleep_ovf |=> cpu_run && pc_sp_reset)
    else $error("overflow wake wrong");
  a_resume_after: assert property (wake_resume |-> cpu_run && $past(state_hold))
    else $error("resume without sleep");
  a_wdt_follows: assert property (!cpu_run |-> wdt_run == wdt_enable)
    else $error("watchdog run wrong");
endmodule
bind pms_power_mode_sequencer pms_props pms_props_i (.*);

// ---- bench/pms_power_mode_sequencer_test.sv ----
// self-checking bench for the power mode sequencer
`timescale 1ns/1ns
module pms_power_mode_sequencer_test;
  logic aclk, aresetn, halt_req, u, s;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_a_in, irq_req, irq_enable, irq_service, c;
  logic [2:0] s_axi_awprot, s_axi_arprot, sysclk_div_exp, m;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, osc_lag;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic halt_exec, clr_wdt_exec, wdt_enable, undervolt_enable, wdt_overflow, fast_osc_ready;
  logic slow_osc_ready, stack_full, cpu_run, state_hold, sysclk_en, sysclk_slow, fast_osc_en;
  logic slow_clk_en, timebase_clk_en, wdt_clk_en, wdt_run, wdt_clear, wake_resume, pc_sp_reset;
  int err_total, cmp_count, w;
  pms_power_mode_sequencer pms_power_mode_sequencer_i (.*);
  pms_core_model pms_core_model_i (.*);
  task automatic conclude();
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic until_slow(input logic v);
    for (int n = 0; n < 40 && sysclk_slow !== v; n++) @(posedge aclk);
  endtask
  function automatic logic [2:0] mode_of(input logic idle, input logic keep, input logic en);
    if (idle) return keep ? 3'h4 : 3'h3;
    return en ? 3'h2 : 3'h1;
  endfunction
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    tick(20000);
    err_total++;
    conclude();
  end
  initial begin
    {aresetn, halt_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, clr_wdt_exec, wdt_enable, undervolt_enable} = '0;
    {wdt_overflow, stack_full, s_axi_awprot, s_axi_arprot, irq_req, irq_enable} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    port_a_in = 8'hFF;
    osc_lag = 4'h3;
    void'($urandom(32'h0ECFDA6C));
    tick(3);
    aresetn <= 1'b1;
    tick(1);
    rd_reg(8'h00);
    chk(rd & 32'hFFFFFFF3, 32'h03);
    for (int k = 1; k < 5; k++) begin
      rd_reg(8'(4 * k));
      chk(rd, k == 2 ? 32'h55 : 32'h00);
    end
    rd_reg(8'h20);
    chk(rd, 32'h0);
    chk(rr, 2'h2);
    wr(8'h24, 32'h01);
    chk(rr, 2'h2);
    s_axi_wstrb <= 4'hE;
    wr(8'h0C, 32'hFF);
    s_axi_wstrb <= 4'hF;
    rd_reg(8'h0C);
    chk(rd, 32'h00);
    wr(8'h04, 32'hFF);
    rd_reg(8'h04);
    chk(rd, 32'h87);
    wr(8'h04, 32'h00);
    // an undefined code keeps the fault up until software clears it
    do c = 8'($urandom) & 8'h7F; while (c == 8'h55 || c == 8'h2A);
    wr(8'h08, {24'h0, c});
    rd_reg(8'h04);
    chk(rd, 32'h08);
    wr(8'h08, 32'h2A);
    rd_reg(8'h04);
    chk(rd, 32'h08);
    wr(8'h04, 32'h00);
    rd_reg(8'h04);
    chk(rd, 32'h00);
    for (int i = 0; i < 8; i++) begin
      m = mode_of(i[0], i[1], i[2]);
      w = i % 3;
      u = 1'($urandom);
      wr(8'h00, {30'h0, i[0], 1'b1});
      wr(8'h04, {24'h0, i[1], 7'h0});
      wr(8'h0C, 32'h01);
      wdt_enable <= i[2] & u;
      undervolt_enable <= i[2] & ~u;
      irq_enable <= 8'($urandom);
      stack_full <= 1'($urandom);
      irq_req <= 8'h02;
      halt_req <= 1'b1;
      @(posedge aclk);
      halt_req <= 1'b0;
      tick(2);
      @(negedge aclk);
      chk(sysclk_en, m == 3'h4);
      chk(timebase_clk_en, m > 3'h2);
      chk(slow_clk_en, m != 3'h1);
      chk(wdt_clk_en, i[2] & u);
      @(posedge aclk);
      rd_reg(8'h10);
      chk(rd, {25'h0, m, 4'h1});
      rd_reg(8'h04);
      chk(rd, {24'h0, i[1], 7'h0});
      port_a_in <= 8'hFD;
      tick(3);
      chk(cpu_run, 1'b0);
      s = irq_enable[2] & ~stack_full;
      case (w)
        0: port_a_in <= 8'hFC;
        1: irq_req <= 8'h06;
        default: wdt_overflow <= 1'b1;
      endcase
      @(posedge aclk);
      wdt_overflow <= 1'b0;
      @(negedge aclk);
      chk(cpu_run, 1'b1);
      chk(wake_resume, w == 0 || (w == 1 && !s));
      chk(irq_service, (w == 1 && s) ? 8'h04 : 8'h00);
      chk(pc_sp_reset, w == 2);
      @(posedge aclk);
      irq_req <= 8'h00;
      port_a_in <= 8'hFF;
      rd_reg(8'h10);
      chk(rd, {30'h0, w == 2, 1'b1});
    end
    clr_wdt_exec <= 1'b1;
    @(posedge aclk);
    clr_wdt_exec <= 1'b0;
    rd_reg(8'h10);
    chk(rd[0], 1'b0);
    // code 8 stands for the plain fast select, every other pass a divider
    for (int d = 2; d < 9; d++) begin
      osc_lag <= 4'($urandom);
      wr(8'h00, {26'h0, d[0], 5'h02});
      until_slow(1'b1);
      chk(sysclk_slow, 1'b1);
      tick(3);
      chk(fast_osc_en, 1'b0);
      wr(8'h00, d == 8 ? 32'h01 : {24'h0, 3'(d), 5'h00});
      rd = 32'h0;
      for (int n = 0; n < 20 && !rd[2]; n++) rd_reg(8'h00);
      until_slow(1'b0);
      // divider output trails the clock source change by one edge
      @(negedge aclk);
      chk(sysclk_div_exp, d == 8 ? 3'h0 : 3'(8 - d));
      @(posedge aclk);
    end
    conclude();
  end
endmodule
